// [verification/pwg_core_model.sv]
// Processor side model that issues peripheral write requests.
`timescale 1ns/1ps
`default_nettype none

module pwg_core_model (
    // Clock.
    input wire logic i_clk,
    // Write request toward the guard.
    output var pwg_pkg::pwg_pw_req_s o_pw
);
    // The request starts idle at time zero.
    initial begin
        o_pw = '0;
    end

    // Waits for the next edge and places one request there; when idle the
    // index flips so that a stale index is never mistaken for a held one.
    task automatic put(input logic v, input logic [4:0] n);
        @(posedge i_clk);
        o_pw.valid <= v;
        o_pw.index <= v ? n : ~o_pw.index;
    endtask
endmodule

`default_nettype wire

// [verification/pwg_guard_tb.sv]
// Self-checking testbench of the peripheral write guard.
`timescale 1ns/1ps
`default_nettype none

module pwg_guard_tb;
    // ========================================================================
    // Signals
    // ========================================================================
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, pw_en, irq;
    logic [31:0] hrdata, prot, rd, rv;
    pwg_pkg::pwg_pw_rsp_s rsp;
    pwg_pkg::pwg_pw_req_s pw;
    // Expected flags, status and mask.
    logic [31:0] e_prot;
    logic [2:0] e_stat, e_mask;
    int mismatches = 0;
    int checks_done = 0;
    integer seed = 32'h5A1F2BCE;

    // The clock runs at 10 MHz.
    always #50 clk = ~clk;

    pwg_guard pwg_guard_i (.i_sys_clk(clk), .i_arst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_pw(pw), .o_pw_write_en(pw_en), .o_pw_rsp(rsp),
        .o_protect(prot), .o_irq(irq));
    pwg_core_model pwg_core_model_i (.i_clk(clk), .o_pw(pw));

    // ========================================================================
    // Tasks
    // ========================================================================
    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; read data is taken at the last edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pwg_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        #1;
    endtask

    // Writes a register and predicts flags, status and interrupt.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        d = v & pwg_pkg::PROT_MASK;
        if (a == pwg_pkg::OFS_SET) begin
            if (|(d & e_prot)) e_stat[2'd1] = 1'b1;
            e_prot = e_prot | d;
        end
        if (a == pwg_pkg::OFS_CLR) begin
            if (|(d & ~e_prot)) e_stat[2'd2] = 1'b1;
            e_prot = e_prot & ~d;
        end
        if (a == pwg_pkg::OFS_STAT) e_stat = e_stat & ~v[2:0];
        if (a == pwg_pkg::OFS_MASK) e_mask = v[2:0];
        bus(1'b1, a, v, rd);
        check(prot, e_prot);
        check({31'h0, irq}, {31'h0, |(e_stat & e_mask)});
        check({31'h0, hresp}, 32'h0);
    endtask

    // Expected guard answer one cycle after a request: done, then the flag.
    function automatic logic [31:0] exp_rsp(input logic flag);
        return {30'h0, 1'b1, flag};
    endfunction

    // Reads a register and compares it.
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        check(rd, e);
    endtask

    // Back-to-back requests to every index, then one idle cycle.
    task automatic pw_sweep();
        for (int n = 0; n < 33; n++) begin
            pwg_core_model_i.put(n < 32, n[4:0]);
            #1;
            if (n < 32) check({31'h0, pw_en}, {31'h0, ~e_prot[n]});
            if (n > 0) check({30'h0, rsp}, exp_rsp(e_prot[n-1]));
            if (n < 32 && e_prot[n]) e_stat[2'd0] = 1'b1;
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        e_prot = pwg_pkg::PROT_RESET;
        e_stat = 3'h0;
        e_mask = 3'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(prot, pwg_pkg::PROT_RESET);
        reg_rd(pwg_pkg::OFS_CLR, 32'h0080_0000);
        reg_rd(pwg_pkg::OFS_SET, 32'h0080_0000);
        pw_sweep();
        reg_wr(pwg_pkg::OFS_MASK, 32'h7);
        reg_wr(pwg_pkg::OFS_SET, 32'hFFFF_FFFF);
        reg_wr(pwg_pkg::OFS_SET, 32'h0000_0002);
        reg_wr(pwg_pkg::OFS_CLR, 32'h0);
        pw_sweep();
        reg_rd(pwg_pkg::OFS_STAT, {29'h0, e_stat});
        reg_wr(pwg_pkg::OFS_STAT, 32'h7);
        reg_wr(pwg_pkg::OFS_CLR, 32'h0000_0100);
        reg_wr(pwg_pkg::OFS_CLR, 32'h0000_0100);
        reg_wr(pwg_pkg::OFS_MASK, 32'h3);
        reg_rd(8'h10, 32'h0);
        reg_wr(8'h10, 32'hFFFF_FFFF);
        // Mid-run reset brings flags, status and mask back to reset.
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check(prot, pwg_pkg::PROT_RESET);
        check({31'h0, irq}, 32'h0);
        check({30'h0, rsp}, 32'h0);
        rst_n <= 1'b1;
        e_prot = pwg_pkg::PROT_RESET;
        e_stat = 3'h0;
        e_mask = 3'h0;
        @(posedge clk);
        #1;
        reg_rd(pwg_pkg::OFS_SET, pwg_pkg::PROT_RESET);
        reg_rd(pwg_pkg::OFS_STAT, 32'h0);
        // Random set and clear words with status readback.
        repeat (40) begin
            rv = $random(seed);
            reg_wr(rv[0] ? pwg_pkg::OFS_SET : pwg_pkg::OFS_CLR, $random(seed));
            reg_rd(pwg_pkg::OFS_CLR, e_prot);
            reg_rd(pwg_pkg::OFS_SET, e_prot);
            if (rv[1]) pw_sweep();
            reg_rd(pwg_pkg::OFS_STAT, {29'h0, e_stat});
            if (rv[2]) reg_wr(pwg_pkg::OFS_STAT, {29'h0, rv[6:4]});
        end
        wrap_up();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(100 * 30000);
        mismatches++;
        wrap_up();
    end
endmodule

`default_nettype wire

// [verilog/pwg_guard.sv]
// Peripheral write guard with its register slave on AHB-Lite.
// Functional notes
// - Zero written to clear view changes nothing.
// - One written to clear view unprotects peripheral.
// - Each bit guards exactly one documented peripheral; only bits 19..1 are assigned, bit 23 stays one.
// - Clear view at 0x00, resets 0x00800000.
// - Set view sets flag; views read alike.
// - Write to protected peripheral discarded, errors.
// - Double protect or unprotect raises error.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pwg_guard #(
    parameter int HADDR_W = 32
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // AHB-Lite slave port.
    input wire logic i_hsel,
    input wire logic [HADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // Peripheral write requests and answers.
    input wire pwg_pkg::pwg_pw_req_s i_pw,
    output logic o_pw_write_en,
    output var pwg_pkg::pwg_pw_rsp_s o_pw_rsp,
    // Protection flags and interrupt.
    output logic [31:0] o_protect,
    output logic o_irq
);

    // ========================================================================
    // Parameter check
    // ========================================================================
    // The decode needs the low eight address bits and at least one bit
    // above them, which must be zero for a hit.
    generate
        if (HADDR_W < 9) begin : g_bad_addr
            $error("HADDR_W must be at least 9");
        end
    endgenerate

    // ========================================================================
    // Decode
    // ========================================================================
    // Maps a byte address to the register it selects.
    function automatic pwg_pkg::pwg_reg_e reg_decode(
        input logic [HADDR_W-1:0] addr
    );
        pwg_pkg::pwg_reg_e sel;
        sel = pwg_pkg::REG_NONE;
        if (addr[HADDR_W-1:8] == '0) begin
            case (addr[7:0])
                pwg_pkg::OFS_CLR: sel = pwg_pkg::REG_CLR;
                pwg_pkg::OFS_SET: sel = pwg_pkg::REG_SET;
                pwg_pkg::OFS_STAT: sel = pwg_pkg::REG_STAT;
                pwg_pkg::OFS_MASK: sel = pwg_pkg::REG_MASK;
                default: sel = pwg_pkg::REG_NONE;
            endcase
        end
        return sel;
    endfunction

    pwg_pkg::pwg_state_s state; // Registered state.
    pwg_pkg::pwg_state_s next_state; // Next value of the state.
    logic addr_phase; // A transfer is taken this cycle.
    logic [31:0] wbits; // Write data limited to assigned bits.
    logic [pwg_pkg::IRQ_W-1:0] irq_event; // Events seen this cycle.
    logic pw_blocked; // Current request hits a protected peripheral.

    // Transfers are taken on a selected, ready, active address phase.
    assign addr_phase = i_hsel && i_hready &&
        (i_htrans == pwg_pkg::HTRANS_NONSEQ ||
         i_htrans == pwg_pkg::HTRANS_SEQ);
    // Writes to unassigned positions are dropped here.
    assign wbits = i_hwdata & pwg_pkg::PROT_MASK;
    // A request is blocked when the flag of its peripheral is set.
    assign pw_blocked = i_pw.valid && state.prot[i_pw.index];

    // ========================================================================
    // Next state
    // ========================================================================
    // Computes bus writes, read data, guard answers and interrupt events.
    always_comb begin
        next_state = state;
        irq_event = '0;
        // Data phase of a write: apply the held register select.
        if (state.wr_pend) begin
            case (state.wr_reg)
                pwg_pkg::REG_CLR: begin
                    // Ones clear the flag, zeros leave it.
                    next_state.prot = state.prot & ~wbits;
                    // Unprotecting a free peripheral is an error.
                    irq_event[pwg_pkg::IRQ_DBL_CLR] =
                        |(wbits & ~state.prot);
                end
                pwg_pkg::REG_SET: begin
                    // Ones set the flag of their peripheral, zeros leave it.
                    next_state.prot = state.prot | wbits;
                    // Protecting a protected peripheral is an error.
                    irq_event[pwg_pkg::IRQ_DBL_SET] = |(wbits & state.prot);
                end
                pwg_pkg::REG_MASK: begin
                    // Mask bits enable interrupt sources.
                    next_state.irq_mask = i_hwdata[pwg_pkg::IRQ_W-1:0];
                end
                default: begin
                    // Status is handled below; unmapped writes are dropped.
                end
            endcase
        end
        // Address phase: latch write select or load the read data.
        next_state.wr_pend = addr_phase && i_hwrite;
        next_state.wr_reg = reg_decode(i_haddr);
        if (addr_phase && !i_hwrite) begin
            case (reg_decode(i_haddr))
                // Both views return the same word.
                pwg_pkg::REG_CLR,
                pwg_pkg::REG_SET: next_state.rdata = state.prot;
                pwg_pkg::REG_STAT: next_state.rdata =
                    {{(32 - pwg_pkg::IRQ_W){1'b0}}, state.irq_stat};
                pwg_pkg::REG_MASK: next_state.rdata =
                    {{(32 - pwg_pkg::IRQ_W){1'b0}}, state.irq_mask};
                default: next_state.rdata = '0;
            endcase
        end
        // Guard answer: blocked writes are refused with an error.
        next_state.rsp.done = i_pw.valid;
        next_state.rsp.error = pw_blocked;
        irq_event[pwg_pkg::IRQ_BLOCKED] = pw_blocked;
        // Sticky status: a new event wins over a same-cycle clear.
        if (state.wr_pend && state.wr_reg == pwg_pkg::REG_STAT) begin
            next_state.irq_stat = state.irq_stat &
                ~i_hwdata[pwg_pkg::IRQ_W-1:0];
        end
        next_state.irq_stat = next_state.irq_stat | irq_event;
        // The fixed bit stays one whatever is written.
        next_state.prot = (next_state.prot & pwg_pkg::PROT_MASK) |
            pwg_pkg::PROT_FIXED;
    end

    // ========================================================================
    // State register
    // ========================================================================
    // Registers the state; reset loads the documented flag word.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state.prot <= pwg_pkg::PROT_RESET;
            state.wr_pend <= 1'b0;
            state.wr_reg <= pwg_pkg::REG_NONE;
            state.rdata <= '0;
            state.irq_stat <= pwg_pkg::IRQ_RESET;
            state.irq_mask <= pwg_pkg::IRQ_RESET;
            state.rsp <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // The slave never inserts wait states and always answers OKAY.
    assign o_hreadyout = 1'b1;
    assign o_hresp = pwg_pkg::HRESP_OKAY;
    assign o_hrdata = state.rdata;
    // The write strobe reaches the peripheral only when unprotected.
    assign o_pw_write_en = i_pw.valid && !state.prot[i_pw.index];
    assign o_pw_rsp = state.rsp;
    assign o_protect = state.prot;
    // Level interrupt from any unmasked status bit.
    assign o_irq = |(state.irq_stat & state.irq_mask);

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    logic seen_edge; // Low until the first edge after reset.
    logic wr_clr; // Data phase of a clear view write.
    logic wr_set; // Data phase of a set view write.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seen_edge <= 1'b0;
        end else begin
            seen_edge <= 1'b1;
        end
    end
    assign wr_clr = state.wr_pend && state.wr_reg == pwg_pkg::REG_CLR;
    assign wr_set = state.wr_pend && state.wr_reg == pwg_pkg::REG_SET;

    zero_keeps_a: assert property (wr_clr |=>
        ((o_protect ^ $past(o_protect)) & ~$past(i_hwdata)) == '0)
        else $error("zero write changed a flag");
    clear_works_a: assert property (wr_clr |=>
        (o_protect & $past(i_hwdata) & pwg_pkg::PROT_MASK) == '0)
        else $error("clear view did not clear");
    bit_map_a: assert property (i_pw.valid |=>
        o_pw_rsp.done && o_pw_rsp.error == !$past(o_pw_write_en))
        else $error("guard bit mapping wrong");
    reset_value_a: assert property (!seen_edge |->
        o_protect == pwg_pkg::PROT_RESET)
        else $error("bad flag reset value");
    set_works_a: assert property (wr_set |=>
        (~o_protect & $past(i_hwdata) & pwg_pkg::PROT_MASK) == '0)
        else $error("set view did not set");
    views_alike_a: assert property (
        addr_phase && !i_hwrite &&
        (reg_decode(i_haddr) == pwg_pkg::REG_CLR ||
         reg_decode(i_haddr) == pwg_pkg::REG_SET)
        |=> o_hrdata == $past(o_protect))
        else $error("views read differently");
    block_error_a: assert property (pw_blocked |=>
        o_pw_rsp.done && o_pw_rsp.error &&
        state.irq_stat[pwg_pkg::IRQ_BLOCKED])
        else $error("protected write not refused");
    double_set_a: assert property (
        wr_set && |(i_hwdata & o_protect & pwg_pkg::PROT_MASK)
        |=> state.irq_stat[pwg_pkg::IRQ_DBL_SET])
        else $error("double protect not flagged");
    double_clr_a: assert property (
        wr_clr && |(i_hwdata & ~o_protect & pwg_pkg::PROT_MASK)
        |=> state.irq_stat[pwg_pkg::IRQ_DBL_CLR])
        else $error("double unprotect not flagged");
    reserved_zero_a: assert property (
        (o_protect & ~(pwg_pkg::PROT_MASK | pwg_pkg::PROT_FIXED)) == '0)
        else $error("unassigned flag bit set");

    unprotect_c: cover property (wr_clr ##[1:20]
        (i_pw.valid && o_pw_write_en));
    blocked_c: cover property (pw_blocked ##1 o_irq);
    double_set_c: cover property (wr_set ##1
        state.irq_stat[pwg_pkg::IRQ_DBL_SET]);

endmodule

`default_nettype wire

// [verilog/pwg_pkg.sv]
// Package with constants, types and state layout of the peripheral guard.
package pwg_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    // Byte offsets of the software visible registers.
    localparam logic [7:0] OFS_CLR = 8'h00;
    localparam logic [7:0] OFS_SET = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    // Reset value of the shared protection word.
    localparam logic [31:0] PROT_RESET = 32'h0080_0000;
    // Bit that always reads back as one.
    localparam logic [31:0] PROT_FIXED = 32'h0080_0000;
    // Assigned protection bits: analog 19..16, timers 15..8, serial 7..2,
    // event system 1.
    localparam logic [31:0] PROT_MASK = 32'h000F_FFFE;
    localparam int ANALOG_LO = 16;
    localparam int TIMER_LO = 8;
    localparam int SERIAL_LO = 2;
    localparam int EVENT_BIT = 1;

    // ========================================================================
    // Interrupt status layout
    // ========================================================================
    localparam int IRQ_W = 3;
    localparam int IRQ_BLOCKED = 0;
    localparam int IRQ_DBL_SET = 1;
    localparam int IRQ_DBL_CLR = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // ========================================================================
    // Bus encodings
    // ========================================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
    localparam int PIDX_W = 5;

    // Register selected by a bus address, one-hot.
    typedef enum logic [4:0] {
        REG_NONE = 5'h01,
        REG_CLR = 5'h02,
        REG_SET = 5'h04,
        REG_STAT = 5'h08,
        REG_MASK = 5'h10
    } pwg_reg_e;

    // Write request from the peripheral bus toward one peripheral.
    typedef struct packed {
        logic valid;
        logic [PIDX_W-1:0] index;
    } pwg_pw_req_s;

    // Registered answer to a peripheral write request.
    typedef struct packed {
        logic done;
        logic error;
    } pwg_pw_rsp_s;

    // Complete state of the guard.
    typedef struct packed {
        logic [31:0] prot;
        logic wr_pend;
        pwg_reg_e wr_reg;
        logic [31:0] rdata;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        pwg_pw_rsp_s rsp;
    } pwg_state_s;

endpackage
